// ---- inc/hci_regs_pkg.sv ----
// register map, field layout and carrier types for the link host controller register bank
package hci_regs_pkg;
   // configuration space decode
   localparam logic [11:0] CFG_BASE_ADDR_OFF = 12'h010;
   localparam logic [11:0] CFG_CYCLE_ADJ_OFF = 12'hC10;
   localparam logic [31:0] BASE_ADDR_RESET = 32'h00000000;
   localparam logic [31:0] CYCLE_ADJ_RESET = 32'h00000000;
   localparam int WIN_ADDR_W = 11;
   localparam logic [31:0] BASE_ADDR_MASK = 32'hFFFFF800;
   // cycle adjustment field layout
   localparam int ADJ_AMOUNT_LSB = 0;
   localparam int ADJ_AMOUNT_W = 4;
   localparam int ADJ_PENDING_BIT = 7;
   // window offsets of the fixed registers
   localparam logic [10:0] OFF_REVISION = 11'h000;
   localparam logic [10:0] OFF_UID_ROM = 11'h004;
   localparam logic [10:0] CLEAR_ALIAS_STEP = 11'h004;
   // set/clear pairs, set alias offset; clear alias follows one word later
   localparam int SC_NUM = 14;
   localparam int SC_HOST_CTRL = 0;
   localparam int SC_RXCH_UP = 1;
   localparam int SC_RXCH_LO = 2;
   localparam int SC_INT_EVT = 3;
   localparam int SC_INT_MSK = 4;
   localparam int SC_TX_EVT = 5;
   localparam int SC_TX_MSK = 6;
   localparam int SC_RX_EVT = 7;
   localparam int SC_RX_MSK = 8;
   localparam int SC_LINK_CTRL = 9;
   localparam int SC_AF_UP = 10;
   localparam int SC_AF_LO = 11;
   localparam int SC_DF_UP = 12;
   localparam int SC_DF_LO = 13;
   localparam logic [10:0] SC_SET_OFF [SC_NUM] = '{11'h050, 11'h070, 11'h078, 11'h080, 11'h088, 11'h090,
      11'h098, 11'h0A0, 11'h0A8, 11'h0E0, 11'h100, 11'h108, 11'h110, 11'h118};
   // pairs whose clear alias reads back masked by the following pair
   localparam logic [SC_NUM-1:0] SC_MASKED_READ = 14'h00A8;
   localparam logic [31:0] SC_RESET = 32'h00000000;
   // plain storage words
   localparam int PL_NUM = 20;
   localparam logic [10:0] PL_OFF [PL_NUM] = '{11'h008, 11'h00C, 11'h010, 11'h014, 11'h018, 11'h01C,
      11'h020, 11'h024, 11'h028, 11'h034, 11'h038, 11'h03C, 11'h040, 11'h064, 11'h068, 11'h0DC,
      11'h0E8, 11'h0EC, 11'h0F0, 11'h120};
   localparam logic [31:0] PL_RESET = 32'h00000000;
   localparam int CYCLE_CNT_W = 12;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [31:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } bus_req_s;

   typedef struct packed {
      logic [31:0] int_evt;
      logic [31:0] tx_evt;
      logic [31:0] rx_evt;
   } hw_event_s;

   typedef struct packed {
      logic [31:0] host_ctrl;
      logic [31:0] link_ctrl;
      logic [63:0] rx_channel_mask;
      logic [63:0] async_filter;
      logic [63:0] direct_filter;
   } ctrl_s;
endpackage

// ---- hdl/link_hci_register_bank.sv ----
// register bank of the serial-bus link host controller with cycle offset adjustment
`timescale 1ns/10ps
`default_nettype none

module link_hci_register_bank #(
   parameter logic [31:0] REVISION_VALUE = 32'h00010000, // arbitrary value
   parameter int unsigned CYCLE_LEN = 3072
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire hci_regs_pkg::bus_req_s cfg_req,
   output logic cfg_ack_q,
   output logic [31:0] cfg_rdata_q,
   input wire hci_regs_pkg::bus_req_s mem_req,
   output logic mem_ack_q,
   output logic [31:0] mem_rdata_q,
   input wire hci_regs_pkg::hw_event_s hw_event,
   output hci_regs_pkg::ctrl_s ctrl,
   output logic [11:0] bus_cycle_counter_q,
   output logic cycle_wrap_q,
   output logic cycle_adjust_pending_q
);

   logic [31:0] base_addr_q;
   logic [3:0] cycle_adjust_amount_q;
   logic [31:0] sc_q [hci_regs_pkg::SC_NUM];
   logic [31:0] sc_d [hci_regs_pkg::SC_NUM];
   logic [31:0] pl_q [hci_regs_pkg::PL_NUM];
   logic [hci_regs_pkg::SC_NUM-1:0] sc_set_hit;
   logic [hci_regs_pkg::SC_NUM-1:0] sc_clr_hit;
   logic [hci_regs_pkg::PL_NUM-1:0] pl_hit;
   logic [31:0] cfg_bm;
   logic [31:0] mem_bm;
   logic [31:0] mem_rdata_d;
   logic [31:0] cfg_rdata_d;
   logic [10:0] mem_off;
   logic mem_hit;
   logic cfg_adj_wr;
   logic cycle_at_end;
   logic [11:0] adj_load;
   logic [11:0] bus_cycle_counter_d;

   // byte enables to a bit mask
   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   assign cfg_bm = lane_mask(cfg_req.be);
   assign mem_bm = lane_mask(mem_req.be);

   // window claim: only accesses that fall inside the 2 Kbyte block are answered
   assign mem_hit = (mem_req.rd | mem_req.wr) &&
      ((mem_req.addr & hci_regs_pkg::BASE_ADDR_MASK) == base_addr_q);
   assign mem_off = {mem_req.addr[10:2], 2'b00};

   // offset decode of the set/clear pairs and plain words
   always_comb begin
      for (int k = 0; k < hci_regs_pkg::SC_NUM; k++) begin
         sc_set_hit[k] = mem_hit && (mem_off == hci_regs_pkg::SC_SET_OFF[k]);
         sc_clr_hit[k] = mem_hit &&
            (mem_off == 11'(hci_regs_pkg::SC_SET_OFF[k] + hci_regs_pkg::CLEAR_ALIAS_STEP));
      end
      for (int j = 0; j < hci_regs_pkg::PL_NUM; j++) begin
         pl_hit[j] = mem_hit && (mem_off == hci_regs_pkg::PL_OFF[j]);
      end
   end

   // next value of each set/clear word; hardware events are merged last so they win over a clear
   always_comb begin
      for (int k = 0; k < hci_regs_pkg::SC_NUM; k++) begin
         sc_d[k] = sc_q[k];
         if (mem_req.wr && sc_clr_hit[k]) begin
            sc_d[k] = sc_d[k] & ~(mem_req.wdata & mem_bm);
         end
         if (mem_req.wr && sc_set_hit[k]) begin
            sc_d[k] = sc_d[k] | (mem_req.wdata & mem_bm);
         end
      end
      sc_d[hci_regs_pkg::SC_INT_EVT] = sc_d[hci_regs_pkg::SC_INT_EVT] | hw_event.int_evt;
      sc_d[hci_regs_pkg::SC_TX_EVT] = sc_d[hci_regs_pkg::SC_TX_EVT] | hw_event.tx_evt;
      sc_d[hci_regs_pkg::SC_RX_EVT] = sc_d[hci_regs_pkg::SC_RX_EVT] | hw_event.rx_evt;
   end

   // set/clear storage, one word behind both aliases
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         for (int k = 0; k < hci_regs_pkg::SC_NUM; k++) begin
            sc_q[k] <= hci_regs_pkg::SC_RESET;
         end
      end else begin
         for (int k = 0; k < hci_regs_pkg::SC_NUM; k++) begin
            sc_q[k] <= sc_d[k];
         end
      end
   end

   // plain read/write words; no output carries them, so only the window read mux reads them
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         for (int j = 0; j < hci_regs_pkg::PL_NUM; j++) begin
            pl_q[j] <= hci_regs_pkg::PL_RESET;
         end
      end else begin
         for (int j = 0; j < hci_regs_pkg::PL_NUM; j++) begin
            if (mem_req.wr && pl_hit[j]) begin
               pl_q[j] <= (pl_q[j] & ~mem_bm) | (mem_req.wdata & mem_bm);
            end
         end
      end
   end

   // window read mux; unmatched offsets fall through to zero
   always_comb begin
      mem_rdata_d = 32'h00000000;
      if (mem_off == hci_regs_pkg::OFF_REVISION) begin
         mem_rdata_d = REVISION_VALUE;
      end
      if (mem_off == hci_regs_pkg::OFF_UID_ROM) begin
         mem_rdata_d = 32'h00000000; // no serial rom behind this bank
      end
      for (int j = 0; j < hci_regs_pkg::PL_NUM; j++) begin
         if (pl_hit[j]) begin
            mem_rdata_d = pl_q[j];
         end
      end
      for (int k = 0; k < hci_regs_pkg::SC_NUM; k++) begin
         if (sc_set_hit[k]) begin
            mem_rdata_d = sc_q[k];
         end
         if (sc_clr_hit[k]) begin
            if (hci_regs_pkg::SC_MASKED_READ[k] && (k + 1 < hci_regs_pkg::SC_NUM)) begin
               mem_rdata_d = sc_q[k] & sc_q[(k + 1) % hci_regs_pkg::SC_NUM];
            end else begin
               mem_rdata_d = sc_q[k];
            end
         end
      end
   end

   // window answer, one cycle after the request
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mem_ack_q <= 1'b0;
         mem_rdata_q <= 32'h00000000;
      end else begin
         mem_ack_q <= mem_hit;
         mem_rdata_q <= (mem_hit && mem_req.rd) ? mem_rdata_d : 32'h00000000;
      end
   end

   // configuration side: window base and adjustment register
   assign cfg_adj_wr = cfg_req.wr && (cfg_req.addr[11:0] == hci_regs_pkg::CFG_CYCLE_ADJ_OFF) && cfg_req.be[0];

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         base_addr_q <= hci_regs_pkg::BASE_ADDR_RESET;
      end else if (cfg_req.wr && (cfg_req.addr[11:0] == hci_regs_pkg::CFG_BASE_ADDR_OFF)) begin
         // low eleven bits stay zero, so the window is 2 Kbyte aligned
         base_addr_q <= ((base_addr_q & ~cfg_bm) | (cfg_req.wdata & cfg_bm))
            & hci_regs_pkg::BASE_ADDR_MASK;
      end
   end

   // amount field; only bits 3-0 take the write
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cycle_adjust_amount_q <= hci_regs_pkg::CYCLE_ADJ_RESET[3:0];
      end else if (cfg_adj_wr) begin
         cycle_adjust_amount_q <= cfg_req.wdata[3:0];
      end
   end

   // pending flag: a fresh write wins over a completion in the same cycle
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cycle_adjust_pending_q <= hci_regs_pkg::CYCLE_ADJ_RESET[7];
      end else if (cfg_adj_wr) begin
         cycle_adjust_pending_q <= 1'b1;
      end else if (cycle_at_end && cycle_adjust_pending_q) begin
         cycle_adjust_pending_q <= 1'b0;
      end
   end

   // configuration read mux
   always_comb begin
      cfg_rdata_d = 32'h00000000;
      if (cfg_req.addr[11:0] == hci_regs_pkg::CFG_BASE_ADDR_OFF) begin
         cfg_rdata_d = base_addr_q;
      end
      if (cfg_req.addr[11:0] == hci_regs_pkg::CFG_CYCLE_ADJ_OFF) begin
         cfg_rdata_d = {24'h000000, cycle_adjust_pending_q, 3'h0, cycle_adjust_amount_q};
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cfg_ack_q <= 1'b0;
         cfg_rdata_q <= 32'h00000000;
      end else begin
         cfg_ack_q <= cfg_req.rd | cfg_req.wr;
         cfg_rdata_q <= cfg_req.rd ? cfg_rdata_d : 32'h00000000;
      end
   end

   // cycle offset counter; an adjustment is taken at a rollover so a cycle is never split
   assign cycle_at_end = (bus_cycle_counter_q == 12'(CYCLE_LEN - 1));
   assign adj_load = cycle_adjust_amount_q[3] ?
      12'(CYCLE_LEN + {{28{1'b1}}, cycle_adjust_amount_q}) : {8'h00, cycle_adjust_amount_q};

   always_comb begin
      bus_cycle_counter_d = 12'(bus_cycle_counter_q + 12'h001);
      if (cycle_at_end) begin
         bus_cycle_counter_d = cycle_adjust_pending_q ? adj_load : 12'h000;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         bus_cycle_counter_q <= 12'h000;
         cycle_wrap_q <= 1'b0;
      end else begin
         bus_cycle_counter_q <= bus_cycle_counter_d;
         cycle_wrap_q <= cycle_at_end;
      end
   end

   // control outputs straight from storage flops
   assign ctrl.host_ctrl = sc_q[hci_regs_pkg::SC_HOST_CTRL];
   assign ctrl.link_ctrl = sc_q[hci_regs_pkg::SC_LINK_CTRL];
   assign ctrl.rx_channel_mask = {sc_q[hci_regs_pkg::SC_RXCH_UP], sc_q[hci_regs_pkg::SC_RXCH_LO]};
   assign ctrl.async_filter = {sc_q[hci_regs_pkg::SC_AF_UP], sc_q[hci_regs_pkg::SC_AF_LO]};
   assign ctrl.direct_filter = {sc_q[hci_regs_pkg::SC_DF_UP], sc_q[hci_regs_pkg::SC_DF_LO]};

   // checks
   default clocking chk_cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   logic [31:0] host_ctrl_w;
   logic [31:0] int_evt_w;
   logic [31:0] int_msk_w;
   assign host_ctrl_w = sc_q[hci_regs_pkg::SC_HOST_CTRL];
   assign int_evt_w = sc_q[hci_regs_pkg::SC_INT_EVT];
   assign int_msk_w = sc_q[hci_regs_pkg::SC_INT_MSK];

   a_set_alias_bits: assert property (
      (mem_req.wr && mem_hit && mem_off == 11'h050)
      |=> host_ctrl_w == ($past(host_ctrl_w) | ($past(mem_req.wdata) & $past(mem_bm))))
      else $error("set alias did not set written ones");

   a_clear_alias_bits: assert property (
      (mem_req.wr && mem_hit && mem_off == 11'h054)
      |=> host_ctrl_w == ($past(host_ctrl_w) & ~($past(mem_req.wdata) & $past(mem_bm))))
      else $error("clear alias did not clear written ones");

   a_event_set_wins: assert property (
      (hw_event.int_evt[0]) |=> int_evt_w[0])
      else $error("hardware event lost against a clear");

   a_masked_clear_read: assert property (
      (mem_req.rd && mem_hit && mem_off == 11'h084)
      |=> mem_ack_q && mem_rdata_q == ($past(int_evt_w) & $past(int_msk_w)))
      else $error("event clear alias not masked");

   a_plain_read_value: assert property (
      (mem_req.rd && !mem_req.wr && mem_hit && mem_off == 11'h054)
      |=> mem_rdata_q == $past(host_ctrl_w) && host_ctrl_w == $past(host_ctrl_w))
      else $error("alias read wrong or had a side effect");

   a_reserved_reads_zero: assert property (
      (mem_req.rd && mem_hit && mem_off == 11'h02C) |=> mem_ack_q && mem_rdata_q == 32'h00000000)
      else $error("reserved offset read nonzero");

   a_pending_on_write: assert property (
      cfg_adj_wr |=> cycle_adjust_pending_q)
      else $error("pending flag not set by amount write");

   a_pending_completion: assert property (
      (cycle_adjust_pending_q && cycle_at_end && !cfg_adj_wr)
      |=> !cycle_adjust_pending_q && bus_cycle_counter_q == $past(adj_load))
      else $error("adjustment not applied at rollover");

   a_pending_holds: assert property (
      (cycle_adjust_pending_q && !cycle_at_end) |=> cycle_adjust_pending_q)
      else $error("pending flag dropped before adjustment");

   a_adj_unused_zero: assert property (
      (cfg_req.rd && cfg_req.addr[11:0] == hci_regs_pkg::CFG_CYCLE_ADJ_OFF)
      |=> cfg_rdata_q[31:8] == 24'h000000 && cfg_rdata_q[6:4] == 3'h0)
      else $error("unused adjustment bits not zero");

   a_window_outside: assert property (
      ((mem_req.rd | mem_req.wr) && (mem_req.addr[31:11] != base_addr_q[31:11])) |=> !mem_ack_q)
      else $error("access outside window answered");

   c_masked_event_read: cover property (mem_req.rd && sc_clr_hit[hci_regs_pkg::SC_INT_EVT] && int_msk_w != 0);
   c_negative_adjust: cover property (cycle_adjust_pending_q && cycle_at_end && cycle_adjust_amount_q[3]);
   c_write_and_apply: cover property (cfg_adj_wr && cycle_at_end && cycle_adjust_pending_q);

endmodule

`default_nettype wire

// ---- verif/bus_host_model.sv ----
// host side model issuing single-word configuration and memory accesses
`timescale 1ns/10ps
`default_nettype none
module bus_host_model (
   input wire logic clk_sys,
   output var hci_regs_pkg::bus_req_s cfg_req,
   output var hci_regs_pkg::bus_req_s mem_req,
   input wire logic cfg_ack_q,
   input wire logic [31:0] cfg_rdata_q,
   input wire logic mem_ack_q,
   input wire logic [31:0] mem_rdata_q
);
   // both ports idle from time zero
   initial begin
      cfg_req = '0;
      mem_req = '0;
   end
   // request stands for exactly one taking edge, since each held cycle is another access;
   // released lines show inverted address and data so no stale value passes as valid
   task automatic access(input logic cfg, input logic wr, input logic [31:0] a, input logic [31:0] d,
      output logic ack, output logic [31:0] rdata);
      hci_regs_pkg::bus_req_s r;
      r = '{rd: !wr, wr: wr, addr: a, be: 4'hF, wdata: d};
      @(negedge clk_sys);
      if (cfg) cfg_req = r;
      else mem_req = r;
      @(negedge clk_sys);
      r = '{rd: 1'b0, wr: 1'b0, addr: ~a, be: 4'h0, wdata: ~d};
      if (cfg) cfg_req = r;
      else mem_req = r;
      ack = cfg ? cfg_ack_q : mem_ack_q;
      rdata = cfg ? cfg_rdata_q : mem_rdata_q;
   endtask
endmodule
`default_nettype wire

// ---- verif/link_hci_register_bank_bench.sv ----
// self-checking bench for the link host controller register bank
`timescale 1ns/10ps
`default_nettype none
module link_hci_register_bank_bench;
   localparam logic [31:0] REV = 32'h00020000; // arbitrary value
   localparam int unsigned CLEN = 16; // short cycle keeps rollovers quick
   // k holds {config port, write, ack expected}; d is write data or expected read data
   typedef struct {logic [2:0] k; logic [31:0] a; logic [31:0] d;} row_s;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   hci_regs_pkg::bus_req_s cfg_req;
   hci_regs_pkg::bus_req_s mem_req;
   hci_regs_pkg::hw_event_s hw_event = '0;
   hci_regs_pkg::ctrl_s ctrl;
   logic cfg_ack_q, mem_ack_q, cycle_wrap_q, cycle_adjust_pending_q, ack;
   logic [31:0] cfg_rdata_q, mem_rdata_q, rdata;
   logic [11:0] bus_cycle_counter_q;
   int errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   row_s rows [39] = '{
      '{3'h7, 32'h10, 32'h1ABC}, '{3'h5, 32'h10, 32'h1800},
      '{3'h1, 32'h1800, REV}, '{3'h0, 32'h50, 32'h0},
      '{3'h3, 32'h1804, 32'hFFFFFFFF}, '{3'h1, 32'h1804, 32'h0},
      '{3'h3, 32'h1870, 32'hF0}, '{3'h3, 32'h1874, 32'h30},
      '{3'h1, 32'h1870, 32'hC0}, '{3'h1, 32'h1874, 32'hC0},
      '{3'h3, 32'h1878, 32'hA5}, '{3'h1, 32'h187C, 32'hA5},
      '{3'h3, 32'h1880, 32'h3C}, '{3'h3, 32'h1888, 32'h0C},
      '{3'h1, 32'h1884, 32'h0C}, '{3'h1, 32'h1880, 32'h3C},
      '{3'h3, 32'h1890, 32'hFF}, '{3'h3, 32'h1898, 32'h0F},
      '{3'h1, 32'h1894, 32'h0F}, '{3'h3, 32'h18A0, 32'hF0},
      '{3'h3, 32'h18A8, 32'h30}, '{3'h1, 32'h18A4, 32'h30},
      '{3'h3, 32'h1900, 32'h1111}, '{3'h3, 32'h1904, 32'h1},
      '{3'h1, 32'h1900, 32'h1110}, '{3'h3, 32'h1908, 32'h22},
      '{3'h3, 32'h1910, 32'h33}, '{3'h3, 32'h1914, 32'h3},
      '{3'h1, 32'h1914, 32'h30}, '{3'h3, 32'h1918, 32'h44},
      '{3'h1, 32'h191C, 32'h44}, '{3'h3, 32'h1838, 32'h12345678},
      '{3'h3, 32'h183C, 32'h9ABCDEF0}, '{3'h1, 32'h1838, 32'h12345678},
      '{3'h1, 32'h183C, 32'h9ABCDEF0}, '{3'h3, 32'h182C, 32'hFFFFFFFF},
      '{3'h1, 32'h182C, 32'h0}, '{3'h1, 32'h1828, 32'h0},
      '{3'h5, 32'h20, 32'h0}};

   link_hci_register_bank #(.REVISION_VALUE(REV), .CYCLE_LEN(CLEN)) i_link_hci_register_bank (
      .clk_sys(clk_sys), .rst_b(rst_b), .cfg_req(cfg_req), .cfg_ack_q(cfg_ack_q),
      .cfg_rdata_q(cfg_rdata_q), .mem_req(mem_req), .mem_ack_q(mem_ack_q), .mem_rdata_q(mem_rdata_q),
      .hw_event(hw_event), .ctrl(ctrl), .bus_cycle_counter_q(bus_cycle_counter_q),
      .cycle_wrap_q(cycle_wrap_q), .cycle_adjust_pending_q(cycle_adjust_pending_q));
   bus_host_model i_bus_host_model (.clk_sys(clk_sys), .cfg_req(cfg_req), .mem_req(mem_req),
      .cfg_ack_q(cfg_ack_q), .cfg_rdata_q(cfg_rdata_q), .mem_ack_q(mem_ack_q), .mem_rdata_q(mem_rdata_q));

   always #20 clk_sys = ~clk_sys;

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // whole run needs under two hundred cycles; this ceiling only catches a hang
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         $display("BAD timeout expected finish seen hang");
         tally_and_finish();
      end
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic acc(input logic cfg, input logic wr, input logic [31:0] a, input logic [31:0] d);
      i_bus_host_model.access(cfg, wr, a, d, ack, rdata);
   endtask

   // bounded wait on negative edges until the cycle counter shows v
   task automatic wait_count(input logic [11:0] v);
      int n;
      n = 0;
      while (bus_cycle_counter_q !== v && n < 40) begin
         @(negedge clk_sys);
         n++;
      end
      chk("count reached", {20'h0, v}, {20'h0, bus_cycle_counter_q});
   endtask

   initial begin
      repeat (20) @(negedge clk_sys);
      rst_b = 1'b1;
      acc(1'b1, 1'b0, 32'hC10, 32'h0);
      chk("adjust reset", 32'h0, rdata);
      chk("pending reset", 32'h0, {31'h0, cycle_adjust_pending_q});
      $display("reset test done");
      for (int i = 0; i < 39; i++) begin
         acc(rows[i].k[2], rows[i].k[1], rows[i].a, rows[i].d);
         chk("ack", {31'h0, rows[i].k[0]}, {31'h0, ack});
         if (!rows[i].k[1]) chk("rdata", rows[i].d, rdata);
      end
      $display("register rows done");
      // event bit 0 still high while software clears bit 0: the event must win
      hw_event.int_evt = 32'h101;
      acc(1'b0, 1'b1, 32'h1884, 32'h1);
      hw_event.int_evt = 32'h0;
      acc(1'b0, 1'b0, 32'h1880, 32'h0);
      chk("event flags", 32'h13D, rdata);
      acc(1'b0, 1'b1, 32'h1850, 32'h3);
      acc(1'b0, 1'b1, 32'h1854, 32'h1);
      chk("host ctrl", 32'h2, ctrl.host_ctrl);
      acc(1'b0, 1'b0, 32'h1854, 32'h0);
      chk("host ctrl read", 32'h2, rdata);
      acc(1'b0, 1'b1, 32'h18E0, 32'h5);
      chk("link ctrl", 32'h5, ctrl.link_ctrl);
      chk("rx mask", 32'hC0, ctrl.rx_channel_mask[63:32]);
      chk("filter", 32'h1110, ctrl.async_filter[63:32]);
      chk("direct filter", 32'h30, ctrl.direct_filter[63:32]);
      chk("direct filter low", 32'h44, ctrl.direct_filter[31:0]);
      $display("alias outputs done");
      // write lands mid-cycle so the rollover edge never races the write; node acts as cycle master
      wait_count(12'h2);
      acc(1'b1, 1'b1, 32'hC10, 32'hFFFFFFF5);
      chk("pending set", 32'h1, {31'h0, cycle_adjust_pending_q});
      acc(1'b1, 1'b0, 32'hC10, 32'h0);
      chk("adjust read", 32'h85, rdata);
      wait_count(12'(CLEN - 1));
      chk("pending held", 32'h1, {31'h0, cycle_adjust_pending_q});
      @(negedge clk_sys);
      chk("load plus", 32'h5, {20'h0, bus_cycle_counter_q});
      chk("wrap pulse", 32'h1, {31'h0, cycle_wrap_q});
      chk("pending clear", 32'h0, {31'h0, cycle_adjust_pending_q});
      wait_count(12'h2);
      acc(1'b1, 1'b1, 32'hC10, 32'h8);
      wait_count(12'(CLEN - 1));
      @(negedge clk_sys);
      chk("load minus", CLEN - 8, {20'h0, bus_cycle_counter_q});
      wait_count(12'(CLEN - 1));
      @(negedge clk_sys);
      chk("plain wrap", 32'h0, {20'h0, bus_cycle_counter_q});
      acc(1'b1, 1'b0, 32'hC10, 32'h0);
      chk("amount kept", 32'h8, rdata);
      $display("adjust test done");
      // second reset in mid-run returns window and storage to zero
      rst_b = 1'b0;
      repeat (3) @(negedge clk_sys);
      rst_b = 1'b1;
      acc(1'b1, 1'b0, 32'h10, 32'h0);
      chk("base reset", 32'h0, rdata);
      acc(1'b0, 1'b0, 32'h50, 32'h0);
      chk("ctrl ack", 32'h1, {31'h0, ack});
      chk("ctrl reset", 32'h0, rdata);
      $display("second reset done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
